// ==== rtl/pcc_lock_timer.sv ====
`timescale 1ns/1ns
`include "pcc_params.svh"

module pcc_lock_timer
    import pcc_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // control
    input  wire logic pll_on,
    input  wire logic restart,
    // status
    output logic      locked
);

    pcc_lock_state_e                 state_reg;
    logic [`PCC_LOCK_CNT_W-1:0]      count_reg;

    // a restart during acquisition reloads the full count
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= PCC_LK_OFF;
            count_reg <= '0;
        end else if (!pll_on) begin
            state_reg <= PCC_LK_OFF;
            count_reg <= '0;
        end else if (restart) begin
            state_reg <= PCC_LK_ACQUIRE;
            count_reg <= `PCC_LOCK_CYCLES;
        end else begin
            unique case (state_reg)
                PCC_LK_OFF: begin
                    state_reg <= PCC_LK_ACQUIRE;
                    count_reg <= `PCC_LOCK_CYCLES;
                end
                PCC_LK_ACQUIRE: begin
                    if (count_reg <= `PCC_LOCK_CNT_W'(1)) begin
                        state_reg <= PCC_LK_LOCKED;
                    end
                    count_reg <= count_reg - `PCC_LOCK_CNT_W'(1);
                end
                PCC_LK_LOCKED: begin
                    count_reg <= '0;
                end
                // the fourth code is unused; fall back to a fresh acquisition
                default: begin
                    state_reg <= PCC_LK_OFF;
                    count_reg <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            locked <= 1'b0;
        end else begin
            locked <= pll_on && !restart && (state_reg == PCC_LK_LOCKED ||
                      (state_reg == PCC_LK_ACQUIRE && count_reg <= `PCC_LOCK_CNT_W'(1)));
        end
    end

endmodule

// ==== rtl/pcc_params.svh ====
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// register placement in the processor bus space
`define PCC_REG_ADDR      12'h0f8
`define PCC_ADDR_W        12

// field positions
`define PCC_WP_BIT        15
`define PCC_DRV_HI        14
`define PCC_DRV_LO        13
`define PCC_PEN_BIT       12
`define PCC_MF_HI         11
`define PCC_MF_LO         0
`define PCC_MF_W          12
`define PCC_MULT_W        13

// reset loads chosen by the mode-select pins
`define PCC_MF_LOAD_X1    12'h000
`define PCC_MF_LOAD_X4    12'h003
`define PCC_MF_LOAD_X401  12'h190
`define PCC_MODE_OFF      2'h0
`define PCC_MODE_X1       2'h1
`define PCC_MODE_X4       2'h2
`define PCC_MODE_X401     2'h3

// worst-case relock time in reference clock cycles
`define PCC_LOCK_CYCLES   12'h9c4
`define PCC_LOCK_CNT_W    12

`endif

// ==== rtl/pcc_pkg.sv ====
package pcc_pkg;

    typedef enum logic [1:0] {
        PCC_DRV_FULL     = 2'h0,
        PCC_DRV_TWO_3RD  = 2'h1,
        PCC_DRV_ONE_3RD  = 2'h2,
        PCC_DRV_OFF      = 2'h3
    } pcc_drive_e;

    typedef enum logic [1:0] {
        PCC_LK_OFF,
        PCC_LK_ACQUIRE,
        PCC_LK_LOCKED
    } pcc_lock_state_e;

    typedef logic [15:0] pcc_word_t;

endpackage

// ==== rtl/pcc_top.sv ====
// Overview of operation
// - 16-bit read/write PLL and clock control register at bus address 0f8.
// - on an 8-bit bus, low byte first; contents apply on the high byte.
// - bit 15 write protect resets to zero; once set, later writes are blocked.
// - PLL multiplier is the 12-bit field plus one, 1 to 4096.
// - a new multiplier drops lock; the PLL-derived system clock stops until relock.
// - clocking resumes within 2500 reference cycles after a multiplier change.
// - reset loads multiplier field 0, 3 or 400 from the mode-select pins.
// - pin codes: 00 PLL off, 01 x1, 10 x4, 11 x401.
// - PLL enable bit 12: software may set, never clear; reset loads it.
// - enable 0 stops oscillator, clocks from crystal; 1 uses PLL output.
// - drive field: full, two-thirds, one-third, off held high; glitch free.
// - system clock from PLL divider when active, else from reference input.
// - baud clock from reference or oscillator, optional divide by two.
// - baud divide control 0 halves the baud clock, 1 passes it.
// - periodic timer always runs from the reference, even during relock.
// - mode pins load enable and multiplier at reset, ignored afterwards.
`timescale 1ns/1ns
`include "pcc_params.svh"

module pcc_top
    import pcc_pkg::*;
(
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,
    // straps
    input  wire logic [1:0]             clock_mode_select_pins,
    input  wire logic                   bus_width_strap,
    // processor bus
    input  wire logic                   bus_sel,
    input  wire logic                   bus_write,
    input  wire logic [`PCC_ADDR_W-1:0] bus_addr,
    input  wire logic                   bus_upper_strobe,
    input  wire logic                   bus_lower_strobe,
    input  wire logic [15:0]            bus_wdata,
    output logic [15:0]                 bus_rdata,
    output logic                        bus_ack,
    // baud configuration from the operation mode register
    input  wire logic                   baud_clock_divide_bit,
    // clock control outputs
    output logic                        pll_enable,
    output logic [`PCC_MULT_W-1:0]      pll_multiplier,
    output logic                        pll_locked,
    output logic                        oscillator_run,
    output logic                        sys_clk_from_pll,
    output logic                        sys_clk_run,
    output logic                        baud_clk_from_vco,
    output logic                        baud_div_by_two,
    output logic                        timer_clk_run,
    output logic [1:0]                  clkout_strength,
    output logic                        clkout_enable,
    output logic                        clkout_pull_high
);

    logic                     mode_loaded_reg;
    logic                     bus_is_8bit_reg;
    logic                     pll_write_protect_reg;
    logic [1:0]               clock_out_drive_field_reg;
    logic                     pll_enable_reg;
    logic [`PCC_MF_W-1:0]     multiplier_field_reg;
    logic [7:0]               pend_low_reg;
    logic                     pend_valid_reg;
    logic                     lock_done;
    pcc_word_t                image;
    pcc_word_t                image_next;
    logic                     reg_hit;
    logic                     write_ok;
    logic                     low_byte_stage;
    logic                     commit;
    logic                     lock_restart;

    // reset load decode, used for the enable bit and the multiplier field
    function automatic logic [`PCC_MF_W:0] mode_load(input logic [1:0] pins);
        logic [`PCC_MF_W:0] val;
        val = '0;
        unique case (pins)
            `PCC_MODE_OFF:   val = {1'b0, `PCC_MF_LOAD_X1};
            `PCC_MODE_X1:    val = {1'b1, `PCC_MF_LOAD_X1};
            `PCC_MODE_X4:    val = {1'b1, `PCC_MF_LOAD_X4};
            `PCC_MODE_X401:  val = {1'b1, `PCC_MF_LOAD_X401};
        endcase
        return val;
    endfunction

    function automatic pcc_word_t lane_merge(input pcc_word_t cur, input pcc_word_t wr,
                                             input logic hi_en, input logic lo_en);
        pcc_word_t res;
        res = cur;
        if (hi_en) begin
            res[15:8] = wr[15:8];
        end
        if (lo_en) begin
            res[7:0] = wr[7:0];
        end
        return res;
    endfunction

    assign image = {pll_write_protect_reg, clock_out_drive_field_reg, pll_enable_reg,
                    multiplier_field_reg};

    assign reg_hit  = bus_sel && mode_loaded_reg &&
                      ({1'b0, bus_addr[`PCC_ADDR_W-1:1]} == (`PCC_REG_ADDR >> 1));
    // a protected write still gets its acknowledge below; it just stores nothing
    assign write_ok = reg_hit && bus_write && !pll_write_protect_reg;

    // big-endian byte order: the odd address carries the low byte
    assign low_byte_stage = write_ok && bus_is_8bit_reg && bus_addr[0];

    always_comb begin
        image_next = image;
        commit     = 1'b0;
        if (write_ok && bus_is_8bit_reg && !bus_addr[0]) begin
            // the high byte applies the staged low byte together with it
            image_next = {bus_wdata[7:0], pend_valid_reg ? pend_low_reg : image[7:0]};
            commit     = 1'b1;
        end else if (write_ok && !bus_is_8bit_reg && (bus_upper_strobe || bus_lower_strobe)) begin
            image_next = lane_merge(image, bus_wdata, bus_upper_strobe, bus_lower_strobe);
            commit     = 1'b1;
        end
    end

    // rewriting the same multiplier keeps lock; a new value or a fresh enable relocks
    assign lock_restart = commit && (image_next[`PCC_MF_HI:`PCC_MF_LO] != multiplier_field_reg ||
                          (image_next[`PCC_PEN_BIT] && !pll_enable_reg));

    // straps are caught at the first edge after release, since async reset takes constants only
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_loaded_reg <= 1'b0;
            bus_is_8bit_reg <= 1'b0;
        end else if (!mode_loaded_reg) begin
            mode_loaded_reg <= 1'b1;
            bus_is_8bit_reg <= !bus_width_strap;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pll_write_protect_reg     <= 1'b0;
            clock_out_drive_field_reg <= PCC_DRV_FULL;
            pll_enable_reg            <= 1'b0;
            multiplier_field_reg      <= '0;
        end else if (!mode_loaded_reg) begin
            {pll_enable_reg, multiplier_field_reg} <= mode_load(clock_mode_select_pins);
        end else if (commit) begin
            pll_write_protect_reg     <= image_next[`PCC_WP_BIT];
            clock_out_drive_field_reg <= image_next[`PCC_DRV_HI:`PCC_DRV_LO];
            pll_enable_reg            <= pll_enable_reg | image_next[`PCC_PEN_BIT];
            multiplier_field_reg      <= image_next[`PCC_MF_HI:`PCC_MF_LO];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_low_reg   <= '0;
            pend_valid_reg <= 1'b0;
        end else if (low_byte_stage) begin
            pend_low_reg   <= bus_wdata[7:0];
            pend_valid_reg <= 1'b1;
        end else if (commit) begin
            pend_valid_reg <= 1'b0;
        end
    end

    pcc_lock_timer u_lock (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .pll_on   (pll_enable_reg),
        .restart  (lock_restart),
        .locked   (lock_done)
    );

    // bus answer one cycle after the strobe; other addresses belong to other blocks
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_ack   <= 1'b0;
            bus_rdata <= '0;
        end else begin
            bus_ack   <= reg_hit;
            bus_rdata <= '0;
            if (reg_hit && !bus_write) begin
                if (bus_is_8bit_reg) begin
                    bus_rdata <= {8'h00, bus_addr[0] ? image[7:0] : image[15:8]};
                end else begin
                    bus_rdata <= image;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pll_enable       <= 1'b0;
            pll_multiplier   <= `PCC_MULT_W'(1);
            pll_locked       <= 1'b0;
            oscillator_run   <= 1'b0;
            sys_clk_from_pll <= 1'b0;
            sys_clk_run      <= 1'b0;
        end else begin
            pll_enable       <= pll_enable_reg;
            pll_multiplier   <= {1'b0, multiplier_field_reg} + `PCC_MULT_W'(1);
            pll_locked       <= lock_done;
            oscillator_run   <= pll_enable_reg;
            sys_clk_from_pll <= pll_enable_reg;
            // crystal-direct clocking never waits for lock
            sys_clk_run      <= !pll_enable_reg || (lock_done && !lock_restart);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            baud_clk_from_vco <= 1'b0;
            baud_div_by_two   <= 1'b0;
            timer_clk_run     <= 1'b0;
        end else begin
            baud_clk_from_vco <= pll_enable_reg;
            baud_div_by_two   <= !baud_clock_divide_bit;
            timer_clk_run     <= 1'b1;
        end
    end

    // registered drive controls keep the pin buffer free of decode spikes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            clkout_strength  <= PCC_DRV_FULL;
            clkout_enable    <= 1'b1;
            clkout_pull_high <= 1'b0;
        end else begin
            clkout_strength  <= clock_out_drive_field_reg;
            clkout_enable    <= clock_out_drive_field_reg != PCC_DRV_OFF;
            clkout_pull_high <= clock_out_drive_field_reg == PCC_DRV_OFF;
        end
    end

    // assertion helpers
    logic [`PCC_LOCK_CNT_W:0] unlock_cnt;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            unlock_cnt <= '0;
        end else if (!pll_enable_reg || lock_done || lock_restart) begin
            unlock_cnt <= '0;
        end else begin
            unlock_cnt <= unlock_cnt + `PCC_LOCK_CNT_W'(1);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_protected_write;
        reg_hit && bus_write && pll_write_protect_reg;
    endsequence

    sequence s_low_byte_write;
        low_byte_stage;
    endsequence

    sequence s_high_byte_commit;
        commit && bus_is_8bit_reg;
    endsequence

    a_wp_blocks_write: assert property (s_protected_write |=> $stable(image) && bus_ack)
        else $error("protected write changed the register");

    a_pen_never_clears: assert property (mode_loaded_reg && pll_enable_reg |=> pll_enable_reg)
        else $error("pll enable cleared after reset");

    a_mult_plus_one: assert property (mode_loaded_reg && $stable(multiplier_field_reg) |=>
                                      pll_multiplier == {1'b0, $past(multiplier_field_reg)} + 13'h1)
        else $error("multiplier output is not field plus one");

    a_low_byte_held: assert property (s_low_byte_write |=> $stable(multiplier_field_reg[7:0])
                                      ##0 pend_valid_reg)
        else $error("low byte applied before high byte");

    a_byte_pair_apply: assert property (s_high_byte_commit ##0 pend_valid_reg
                                        |=> multiplier_field_reg[7:0] == $past(pend_low_reg))
        else $error("staged low byte not applied with high byte");

    a_lock_drops: assert property (lock_restart |=> !lock_done ##1 !pll_locked && !sys_clk_run)
        else $error("lock held across multiplier change");

    a_relock_bound: assert property (unlock_cnt <= (`PCC_LOCK_CNT_W+1)'(`PCC_LOCK_CYCLES) + 13'h1)
        else $error("relock took longer than allowed");

    a_mode_load: assert property ($rose(mode_loaded_reg) |->
                                  {pll_enable_reg, multiplier_field_reg} == mode_load($past(clock_mode_select_pins)))
        else $error("reset load does not follow mode pins");

    a_pins_ignored: assert property (mode_loaded_reg && !commit |=> $stable(multiplier_field_reg))
        else $error("multiplier moved without a write");

    a_clkout_off: assert property (clock_out_drive_field_reg == PCC_DRV_OFF |=>
                                   !clkout_enable && clkout_pull_high)
        else $error("clock out not disabled");

    a_bus_ack_time: assert property (reg_hit |=> bus_ack)
        else $error("register access not acknowledged");

    a_ack_single: assert property (!reg_hit |=> !bus_ack)
        else $error("acknowledge without a register access");

    a_timer_free: assert property (mode_loaded_reg && !lock_done |=> timer_clk_run)
        else $error("timer clock stopped during relock");

endmodule

// ==== verif/test_pll_clock_control.sv ====
`timescale 1ns/1ns
`include "pcc_params.svh"

module test_pll_clock_control
    import pcc_pkg::*;
;
    logic                   core_clk = 1'b0;
    logic                   reset_n = 1'b0;
    logic [1:0]             clock_mode_select_pins = 2'h0;
    logic                   bus_width_strap = 1'b1;
    logic                   bus_sel = 1'b0;
    logic                   bus_write = 1'b0;
    logic [`PCC_ADDR_W-1:0] bus_addr = 12'h000;
    logic                   bus_upper_strobe = 1'b0;
    logic                   bus_lower_strobe = 1'b0;
    logic [15:0]            bus_wdata = 16'h0000;
    logic                   baud_clock_divide_bit = 1'b0;
    logic [15:0]            bus_rdata;
    logic                   bus_ack;
    logic                   pll_enable;
    logic [`PCC_MULT_W-1:0] pll_multiplier;
    logic                   pll_locked;
    logic                   oscillator_run;
    logic                   sys_clk_from_pll;
    logic                   sys_clk_run;
    logic                   baud_clk_from_vco;
    logic                   baud_div_by_two;
    logic                   timer_clk_run;
    logic [1:0]             clkout_strength;
    logic                   clkout_enable;
    logic                   clkout_pull_high;
    int                     errors = 0;
    int                     compares = 0;
    int                     cycles = 0;
    logic [31:0]            seed = 32'd91845;
    logic [31:0]            r;
    logic                   chg;
    pcc_word_t              img;
    logic [16:0]            rq[$];

    pcc_top dut_u (.core_clk, .reset_n, .clock_mode_select_pins, .bus_width_strap, .bus_sel, .bus_write,
                   .bus_addr, .bus_upper_strobe, .bus_lower_strobe, .bus_wdata, .bus_rdata, .bus_ack,
                   .baud_clock_divide_bit, .pll_enable, .pll_multiplier, .pll_locked, .oscillator_run,
                   .sys_clk_from_pll, .sys_clk_run, .baud_clk_from_vco, .baud_div_by_two, .timer_clk_run,
                   .clkout_strength, .clkout_enable, .clkout_pull_high);

    always #5 core_clk = ~core_clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic test_done();
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        compares++;
        if (seen !== expv) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    // each note is {compare read data, expected data}
    always @(negedge core_clk) begin
        if (bus_ack === 1'b1) begin
            if (rq.size() == 0) begin
                check(16'h0001, 16'h0000);
            end else begin
                if (rq[0][16]) begin
                    check(bus_rdata, rq[0][15:0]);
                end
                void'(rq.pop_front());
            end
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            test_done();
        end
    end

    // one-cycle select pulse; data is scrambled once released so a stale bus never passes
    task automatic access(input logic wr, input logic [11:0] addr, input logic [1:0] stb,
                          input logic [15:0] wd, input logic hit, input logic [15:0] exp_rd);
        @(negedge core_clk);
        bus_sel = 1'b1;
        bus_write = wr;
        bus_addr = addr;
        {bus_upper_strobe, bus_lower_strobe} = stb;
        bus_wdata = wd;
        if (hit) rq.push_back({~wr, exp_rd});
        @(negedge core_clk);
        bus_sel = 1'b0;
        bus_wdata = ~wd;
        bus_addr = ~addr;
        @(negedge core_clk);
        check(16'(rq.size()), 16'h0000);
    endtask

    task automatic wr16(input logic [15:0] d, output logic c);
        logic [15:0] nxt;
        nxt = img[15] ? img : {d[15:13], d[12] | img[12], d[11:0]};
        c = (nxt[11:0] != img[11:0]) || (nxt[12] && !img[12]);
        access(1'b1, 12'h0f8, 2'h3, d, 1'b1, 16'h0000);
        img = nxt;
    endtask

    task automatic rd16();
        access(1'b0, 12'h0f8, 2'h3, 16'(xs()), 1'b1, img);
    endtask

    task automatic check_outs();
        logic [31:0] v;
        @(negedge core_clk);
        v = xs();
        baud_clock_divide_bit = v[0];
        @(negedge core_clk);
        check(16'(pll_enable), 16'(img[12]));
        check(16'(pll_multiplier), 16'(img[11:0]) + 16'h0001);
        check(16'({oscillator_run, sys_clk_from_pll}), {14'h0, {2{img[12]}}});
        check(16'(baud_clk_from_vco), 16'(img[12]));
        check(16'(clkout_strength), 16'(img[14:13]));
        check(16'({clkout_enable, clkout_pull_high}), (img[14:13] == 2'h3) ? 16'h0001 : 16'h0002);
        check(16'(baud_div_by_two), {15'h0, ~baud_clock_divide_bit});
        check(16'(timer_clk_run), 16'h0001);
    endtask

    task automatic wait_lock(input int lo);
        int n;
        n = 0;
        while (pll_locked !== 1'b1 && n < 2600) begin
            @(negedge core_clk);
            n++;
        end
        check(16'(n >= lo && n < 2504), 16'h0001);
        check(16'(sys_clk_run), 16'h0001);
    endtask

    // pins change right after the capture edge, which must not matter
    task automatic do_reset(input logic [1:0] m, input logic w);
        @(negedge core_clk);
        reset_n = 1'b0;
        clock_mode_select_pins = m;
        bus_width_strap = w;
        repeat (8) @(negedge core_clk);
        reset_n = 1'b1;
        @(negedge core_clk);
        clock_mode_select_pins = ~m;
        bus_width_strap = ~w;
        @(negedge core_clk);
        img = {3'h0, m != 2'h0, (m == 2'h3) ? 12'h190 : (m == 2'h2) ? 12'h003 : 12'h000};
    endtask

    initial begin
        for (int m = 0; m < 4; m++) begin
            do_reset(2'(m), 1'b1);
            rd16();
            check_outs();
            check(16'(sys_clk_run), 16'(m == 0));
        end
        wait_lock(0);
        for (int k = 0; k < 4; k++) begin
            r = xs();
            // the reference rate is not modelled, so every field stands for a legal oscillator rate
            r[11:0] = (k == 0) ? 12'hfff : (k == 1) ? 12'h000 : r[11:0];
            wr16({1'b0, 2'(k), r[12], r[11:0]}, chg);
            @(negedge core_clk);
            check(16'({pll_locked, sys_clk_run, timer_clk_run}), {13'h0, ~chg, ~chg, 1'b1});
            check_outs();
            rd16();
            wait_lock(chg ? 2400 : 0);
        end
        wr16(img, chg);
        repeat (3) @(negedge core_clk);
        check(16'(pll_locked), 16'h0001);
        access(1'b0, 12'h0fa, 2'h3, 16'h0000, 1'b0, 16'h0000);
        access(1'b1, 12'h0f6, 2'h3, 16'(xs()), 1'b0, 16'h0000);
        access(1'b1, 12'h0f8, 2'h0, 16'(xs()), 1'b1, 16'h0000);
        rd16();
        wr16({1'b1, 2'h3, img[12:0] ^ 13'h0005}, chg);
        rd16();
        check_outs();
        wr16(16'(xs()), chg);
        rd16();
        check_outs();
        do_reset(2'h0, 1'b0);
        check_outs();
        check(16'(pll_locked), 16'h0000);
        r = xs();
        access(1'b1, 12'h0f9, 2'h0, {8'h00, r[7:0]}, 1'b1, 16'h0000);
        access(1'b0, 12'h0f9, 2'h0, 16'h0000, 1'b1, 16'h0000);
        check(16'(pll_multiplier), 16'h0001);
        access(1'b1, 12'h0f8, 2'h3, 16'h0012, 1'b1, 16'h0000);
        img = {8'h12, r[7:0]};
        check_outs();
        access(1'b1, 12'h0f8, 2'h0, 16'h0002, 1'b1, 16'h0000);
        access(1'b0, 12'h0f8, 2'h0, 16'h0000, 1'b1, 16'h0012);
        access(1'b0, 12'h0f9, 2'h0, 16'h0000, 1'b1, {8'h00, r[7:0]});
        wait_lock(0);
        test_done();
    end
endmodule
